// file: hw/cra_endpoint.sv
// Configuration endpoint: decodes request messages and sends the answers
`timescale 1ns/1ps
module cra_endpoint #(
  parameter logic [15:0] TILE_ID = 16'h0000,
  parameter logic [15:0] NODE_ID = 16'h0000
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  cra_if.endpoint LINK,
  output logic CFG_REQ_O,
  output logic CFG_WR_O,
  output cra_pkg::cra_space_t CFG_SPACE_O,
  output logic [15:0] CFG_ADDR_O,
  output logic [31:0] CFG_WDATA_O,
  output logic [7:0] CFG_SIZE_O,
  input wire logic CFG_ACK_I,
  input wire logic CFG_OK_I,
  input wire logic [31:0] CFG_RDATA_I
);

  // ==========================================================================
  // State
  cra_pkg::cra_ep_state_t state_reg;
  cra_pkg::cra_ep_state_t state_next;
  cra_pkg::cra_ep_state_t field_after;
  cra_pkg::cra_space_t space_reg;
  cra_pkg::cra_space_t hdr_space;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic [7:0] need;
  logic ready_reg;
  logic wr_reg;
  logic hdr_wr;
  logic hdr_ok;
  logic [23:0] rid_reg;
  logic [15:0] addr_reg;
  logic [7:0] size_reg;
  logic [31:0] data_reg;
  logic [31:0] rdata_reg;
  logic ok_reg;
  logic ok_next;
  logic req_reg;
  logic [7:0] ridx_reg;
  logic rsp_valid_reg;
  logic rsp_ctrl_reg;
  logic [7:0] rsp_data_reg;
  logic [23:0] rsp_dest_reg;
  logic take;
  logic rsp_take;
  logic is_end;
  logic last;
  logic size_ok;
  logic [7:0] nb_rsp;
  logic tile_hit;
  logic node_hit;
  logic per_hit;

  assign take = LINK.req_valid & ready_reg;
  assign rsp_take = rsp_valid_reg & LINK.rsp_ready;
  assign is_end = LINK.req_ctrl && (LINK.req_data == cra_pkg::TOK_END);
  assign last = (cnt_reg == need - 8'h01);
  assign size_ok = (size_reg != 8'h00) && (size_reg <= cra_pkg::MAX_PER_BYTES);
  assign nb_rsp = (ok_reg && !wr_reg) ? size_reg : 8'h00;

  // ==========================================================================
  // Header decode
  always_comb begin
    tile_hit = (LINK.req_dest[15:0] == cra_pkg::DST_TILE) &&
      (LINK.req_dest[31:16] == TILE_ID);
    node_hit = (LINK.req_dest[15:0] == cra_pkg::DST_NODE) &&
      (LINK.req_dest[31:16] == NODE_ID);
    per_hit = (LINK.req_dest[7:0] == cra_pkg::DST_PERIPH) &&
      (LINK.req_dest[31:16] == NODE_ID);
    hdr_ok = 1'b0;
    hdr_wr = 1'b0;
    hdr_space = cra_pkg::CRA_SP_TILE;
    if ((tile_hit || node_hit) &&
        ((LINK.req_data == cra_pkg::TOK_CFG_WR) ||
         (LINK.req_data == cra_pkg::TOK_CFG_RD))) begin
      hdr_ok = 1'b1;
      hdr_wr = (LINK.req_data == cra_pkg::TOK_CFG_WR);
      hdr_space = tile_hit ? cra_pkg::CRA_SP_TILE : cra_pkg::CRA_SP_NODE;
    end else if (per_hit &&
        ((LINK.req_data == cra_pkg::TOK_PER_WR) ||
         (LINK.req_data == cra_pkg::TOK_PER_RD))) begin
      hdr_ok = 1'b1;
      hdr_wr = (LINK.req_data == cra_pkg::TOK_PER_WR);
      hdr_space = cra_pkg::CRA_SP_PERIPH;
    end
  end

  // ==========================================================================
  // Field lengths and order
  always_comb begin
    need = 8'h01;
    field_after = cra_pkg::EP_TAIL;
    case (state_reg)
      cra_pkg::EP_RID: begin
        need = cra_pkg::RID_BYTES;
        field_after = cra_pkg::EP_REG;
      end
      cra_pkg::EP_REG: begin
        if (space_reg == cra_pkg::CRA_SP_PERIPH) begin
          need = cra_pkg::PER_REG_BYTES;
          field_after = cra_pkg::EP_SIZE;
        end else begin
          need = cra_pkg::CFG_REG_BYTES;
          field_after = wr_reg ? cra_pkg::EP_DATA : cra_pkg::EP_TAIL;
        end
      end
      cra_pkg::EP_SIZE: begin
        field_after = (wr_reg && LINK.req_data != 8'h00) ?
          cra_pkg::EP_DATA : cra_pkg::EP_TAIL;
      end
      cra_pkg::EP_DATA: begin
        need = size_reg;
      end
      default: begin
        need = 8'h01;
      end
    endcase
  end

  // ==========================================================================
  // Message sequencer
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    ok_next = ok_reg;
    case (state_reg)
      cra_pkg::EP_HEAD: begin
        if (take) begin
          cnt_next = 8'h00;
          if (LINK.req_ctrl && hdr_ok) begin
            state_next = cra_pkg::EP_RID;
          end else if (!is_end) begin
            state_next = cra_pkg::EP_DROP;
          end
        end
      end
      cra_pkg::EP_RID, cra_pkg::EP_REG, cra_pkg::EP_SIZE,
      cra_pkg::EP_DATA: begin
        if (take && LINK.req_ctrl) begin
          state_next = is_end ? cra_pkg::EP_HEAD : cra_pkg::EP_DROP;
        end else if (take && last) begin
          cnt_next = 8'h00;
          state_next = field_after;
        end else if (take) begin
          cnt_next = cnt_reg + 8'h01;
        end
      end
      cra_pkg::EP_TAIL: begin
        if (take) begin
          if (!is_end) begin
            state_next = cra_pkg::EP_DROP;
          end else if (size_ok) begin
            state_next = cra_pkg::EP_EXEC;
          end else begin
            state_next = cra_pkg::EP_SEND;
            ok_next = 1'b0;
          end
        end
      end
      cra_pkg::EP_DROP: begin
        if (take && is_end) begin
          state_next = cra_pkg::EP_HEAD;
        end
      end
      cra_pkg::EP_EXEC: begin
        if (CFG_ACK_I) begin
          state_next = cra_pkg::EP_SEND;
          ok_next = CFG_OK_I;
        end
      end
      cra_pkg::EP_SEND: begin
        if (rsp_take && (ridx_reg == nb_rsp + 8'h01)) begin
          state_next = cra_pkg::EP_HEAD;
        end
      end
      default: begin
        state_next = cra_pkg::EP_HEAD;
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      state_reg <= cra_pkg::EP_HEAD;
      cnt_reg <= 8'h00;
      ok_reg <= 1'b0;
      ready_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      ok_reg <= ok_next;
      ready_reg <= (state_next != cra_pkg::EP_EXEC) &&
        (state_next != cra_pkg::EP_SEND);
    end
  end

  // ==========================================================================
  // Field capture, most significant byte first
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      space_reg <= cra_pkg::CRA_SP_TILE;
      wr_reg <= 1'b0;
      rid_reg <= 24'h00_0000;
      addr_reg <= 16'h0000;
      size_reg <= 8'h00;
      data_reg <= 32'h0000_0000;
    end else if (take && !LINK.req_ctrl) begin
      case (state_reg)
        cra_pkg::EP_RID: rid_reg <= {rid_reg[15:0], LINK.req_data};
        cra_pkg::EP_REG: addr_reg <= {addr_reg[7:0], LINK.req_data};
        cra_pkg::EP_SIZE: size_reg <= LINK.req_data;
        cra_pkg::EP_DATA: data_reg <= {data_reg[23:0], LINK.req_data};
        default: begin
        end
      endcase
    end else if (take && state_reg == cra_pkg::EP_HEAD && hdr_ok) begin
      space_reg <= hdr_space;
      wr_reg <= hdr_wr;
      addr_reg <= 16'h0000;
      data_reg <= 32'h0000_0000;
      size_reg <= (hdr_space == cra_pkg::CRA_SP_PERIPH) ? 8'h00 :
        cra_pkg::CFG_DATA_BYTES;
    end
  end

  // ==========================================================================
  // Register side request
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      req_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      req_reg <= (state_reg == cra_pkg::EP_TAIL) &&
        (state_next == cra_pkg::EP_EXEC);
      if (state_reg == cra_pkg::EP_EXEC && CFG_ACK_I) begin
        rdata_reg <= CFG_RDATA_I;
      end
    end
  end

  // ==========================================================================
  // Response tokens
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      rsp_valid_reg <= 1'b0;
      rsp_ctrl_reg <= 1'b0;
      rsp_data_reg <= 8'h00;
      rsp_dest_reg <= 24'h00_0000;
      ridx_reg <= 8'h00;
    end else if (state_reg != cra_pkg::EP_SEND &&
        state_next == cra_pkg::EP_SEND) begin
      rsp_valid_reg <= 1'b1;
      rsp_ctrl_reg <= 1'b1;
      rsp_data_reg <= ok_next ? cra_pkg::TOK_ACK : cra_pkg::TOK_NAK;
      rsp_dest_reg <= rid_reg;
      ridx_reg <= 8'h00;
    end else if (rsp_take) begin
      if (ridx_reg == nb_rsp + 8'h01) begin
        rsp_valid_reg <= 1'b0;
      end else if (ridx_reg < nb_rsp) begin
        rsp_ctrl_reg <= 1'b0;
        rsp_data_reg <= cra_pkg::cra_pick(rdata_reg, ridx_reg, nb_rsp);
        ridx_reg <= ridx_reg + 8'h01;
      end else begin
        rsp_ctrl_reg <= 1'b1;
        rsp_data_reg <= cra_pkg::TOK_END;
        ridx_reg <= ridx_reg + 8'h01;
      end
    end
  end

  assign LINK.req_ready = ready_reg;
  assign LINK.rsp_valid = rsp_valid_reg;
  assign LINK.rsp_ctrl = rsp_ctrl_reg;
  assign LINK.rsp_data = rsp_data_reg;
  assign LINK.rsp_dest = rsp_dest_reg;
  assign CFG_REQ_O = req_reg;
  assign CFG_WR_O = wr_reg;
  assign CFG_SPACE_O = space_reg;
  assign CFG_ADDR_O = addr_reg;
  assign CFG_WDATA_O = data_reg;
  assign CFG_SIZE_O = size_reg;

endmodule : cra_endpoint

// file: hw/cra_requester.sv
// Requesting channel-end: frames request messages and collects the answer
`timescale 1ns/1ps
module cra_requester (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  cra_if.requester LINK,
  input wire logic START_I,
  input wire logic WR_I,
  input wire cra_pkg::cra_space_t SPACE_I,
  input wire logic [15:0] TARGET_I,
  input wire logic [7:0] PERIPH_I,
  input wire logic [23:0] REPLY_I,
  input wire logic [15:0] ADDR_I,
  input wire logic [7:0] SIZE_I,
  input wire logic [31:0] WDATA_I,
  input wire logic [15:0] PS_REG_I,
  output logic BUSY_O,
  output logic DONE_O,
  output logic OK_O,
  output logic [31:0] RDATA_O,
  output logic [31:0] PS_RID_O
);

  // ==========================================================================
  // State
  cra_pkg::cra_rq_state_t state_reg;
  cra_pkg::cra_rq_state_t state_next;
  logic wr_reg;
  logic per_reg;
  logic [23:0] rid_reg;
  logic [15:0] addr_reg;
  logic [7:0] size_reg;
  logic [31:0] wdata_reg;
  logic [31:0] dest_reg;
  logic [7:0] idx_reg;
  logic [7:0] cnt_reg;
  logic [8:0] tok;
  logic [7:0] ndata;
  logic [7:0] nrd;
  logic valid_reg;
  logic [8:0] out_reg;
  logic rready_reg;
  logic done_reg;
  logic ok_reg;
  logic [31:0] rdata_reg;
  logic [31:0] ps_rid_reg;
  logic busy_reg;
  logic take;
  logic rtake;
  logic mine;

  assign take = valid_reg & LINK.req_ready;
  assign rtake = rready_reg & LINK.rsp_valid;
  assign mine = rtake && (LINK.rsp_dest == rid_reg);
  assign ndata = wr_reg ? size_reg : 8'h00;
  assign nrd = wr_reg ? 8'h00 : size_reg;

  // ==========================================================================
  // Token that follows the one being sent
  always_comb begin
    logic [7:0] i;
    i = idx_reg + 8'h01;
    if (i < 8'h04) begin
      tok = {1'b0, cra_pkg::cra_pick({8'h00, rid_reg}, i - 8'h01,
        cra_pkg::RID_BYTES)};
    end else if (i == 8'h04) begin
      tok = {1'b0, per_reg ? addr_reg[7:0] : addr_reg[15:8]};
    end else if (i == 8'h05) begin
      tok = {1'b0, per_reg ? size_reg : addr_reg[7:0]};
    end else if (i < cra_pkg::REQ_DATA_POS + ndata) begin
      tok = {1'b0, cra_pkg::cra_pick(wdata_reg, i - cra_pkg::REQ_DATA_POS,
        ndata)};
    end else begin
      tok = {1'b1, cra_pkg::TOK_END};
    end
  end

  // ==========================================================================
  // Sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      cra_pkg::RQ_IDLE: if (START_I) state_next = cra_pkg::RQ_SEND;
      cra_pkg::RQ_SEND: begin
        if (take && idx_reg == cra_pkg::REQ_DATA_POS + ndata) begin
          state_next = cra_pkg::RQ_HEAD;
        end
      end
      cra_pkg::RQ_HEAD: begin
        if (mine && LINK.rsp_ctrl && LINK.rsp_data == cra_pkg::TOK_ACK) begin
          state_next = (nrd == 8'h00) ? cra_pkg::RQ_TAIL : cra_pkg::RQ_DATA;
        end else if (mine && LINK.rsp_ctrl &&
            LINK.rsp_data == cra_pkg::TOK_NAK) begin
          state_next = cra_pkg::RQ_TAIL;
        end
      end
      cra_pkg::RQ_DATA: begin
        if (mine && LINK.rsp_ctrl) begin
          state_next = cra_pkg::RQ_IDLE;
        end else if (mine && cnt_reg == nrd - 8'h01) begin
          state_next = cra_pkg::RQ_TAIL;
        end
      end
      cra_pkg::RQ_TAIL: begin
        if (mine && LINK.rsp_ctrl && LINK.rsp_data == cra_pkg::TOK_END) begin
          state_next = cra_pkg::RQ_IDLE;
        end
      end
      default: state_next = cra_pkg::RQ_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      state_reg <= cra_pkg::RQ_IDLE;
      rready_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      rready_reg <= (state_next == cra_pkg::RQ_HEAD) ||
        (state_next == cra_pkg::RQ_DATA) || (state_next == cra_pkg::RQ_TAIL);
      busy_reg <= (state_next != cra_pkg::RQ_IDLE);
    end
  end

  // ==========================================================================
  // Request capture and token output
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      wr_reg <= 1'b0;
      per_reg <= 1'b0;
      rid_reg <= 24'h00_0000;
      addr_reg <= 16'h0000;
      size_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      dest_reg <= 32'h0000_0000;
      idx_reg <= 8'h00;
      valid_reg <= 1'b0;
      out_reg <= 9'h000;
    end else if (state_reg == cra_pkg::RQ_IDLE && START_I) begin
      wr_reg <= WR_I;
      per_reg <= (SPACE_I == cra_pkg::CRA_SP_PERIPH);
      rid_reg <= REPLY_I;
      addr_reg <= ADDR_I;
      wdata_reg <= WDATA_I;
      idx_reg <= 8'h00;
      valid_reg <= 1'b1;
      if (SPACE_I == cra_pkg::CRA_SP_PERIPH) begin
        size_reg <= SIZE_I;
        dest_reg <= {TARGET_I, PERIPH_I, cra_pkg::DST_PERIPH};
        out_reg <= {1'b1, WR_I ? cra_pkg::TOK_PER_WR : cra_pkg::TOK_PER_RD};
      end else begin
        size_reg <= cra_pkg::CFG_DATA_BYTES;
        dest_reg <= {TARGET_I, (SPACE_I == cra_pkg::CRA_SP_TILE) ?
          cra_pkg::DST_TILE : cra_pkg::DST_NODE};
        out_reg <= {1'b1, WR_I ? cra_pkg::TOK_CFG_WR : cra_pkg::TOK_CFG_RD};
      end
    end else if (take) begin
      if (idx_reg == cra_pkg::REQ_DATA_POS + ndata) begin
        valid_reg <= 1'b0;
      end else begin
        idx_reg <= idx_reg + 8'h01;
        out_reg <= tok;
      end
    end
  end

  // ==========================================================================
  // Answer collection
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      cnt_reg <= 8'h00;
      ok_reg <= 1'b0;
      done_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      ps_rid_reg <= 32'h0000_0000;
    end else begin
      ps_rid_reg <= cra_pkg::cra_ps_rid(PS_REG_I);
      done_reg <= (state_reg != cra_pkg::RQ_IDLE) &&
        (state_next == cra_pkg::RQ_IDLE);
      if (state_reg == cra_pkg::RQ_IDLE && START_I) begin
        cnt_reg <= 8'h00;
        rdata_reg <= 32'h0000_0000;
      end else if (state_reg == cra_pkg::RQ_HEAD && mine && LINK.rsp_ctrl) begin
        ok_reg <= (LINK.rsp_data == cra_pkg::TOK_ACK);
      end else if (state_reg == cra_pkg::RQ_DATA && mine) begin
        if (LINK.rsp_ctrl) begin
          ok_reg <= 1'b0;
        end else begin
          rdata_reg <= {rdata_reg[23:0], LINK.rsp_data};
          cnt_reg <= cnt_reg + 8'h01;
        end
      end
    end
  end

  assign LINK.req_valid = valid_reg;
  assign LINK.req_ctrl = out_reg[8];
  assign LINK.req_data = out_reg[7:0];
  assign LINK.req_dest = dest_reg;
  assign LINK.rsp_ready = rready_reg;
  assign BUSY_O = busy_reg;
  assign DONE_O = done_reg;
  assign OK_O = ok_reg;
  assign RDATA_O = rdata_reg;
  assign PS_RID_O = ps_rid_reg;

endmodule : cra_requester

// file: inc/cra_if.sv
// Token link between a requesting channel-end and the configuration endpoint
`timescale 1ns/1ps
interface cra_if;
  logic req_valid;
  logic req_ready;
  logic req_ctrl;
  logic [7:0] req_data;
  logic [31:0] req_dest;
  logic rsp_valid;
  logic rsp_ready;
  logic rsp_ctrl;
  logic [7:0] rsp_data;
  logic [23:0] rsp_dest;

  modport endpoint(input req_valid, req_ctrl, req_data, req_dest, rsp_ready,
    output req_ready, rsp_valid, rsp_ctrl, rsp_data, rsp_dest);
  modport requester(output req_valid, req_ctrl, req_data, req_dest,
    rsp_ready, input req_ready, rsp_valid, rsp_ctrl, rsp_data, rsp_dest);
endinterface : cra_if

// file: inc/cra_pkg.sv
// Shared constants, types and helpers of the configuration access link
// What this block does
// - Status register id is number shifted eight, 0x0C
// - Tile destination: tile id over low code C20C
// - Config write: 192, reply id, register, data, 1
// - Write answers 3,1 on success, 4,1 failure
// - Config read: 193, reply id, register, 1
// - Config read answers 3, word, 1 or 4,1
// - Node destination: node id over low code C30C
// - Peripheral destination: node id, peripheral byte, 02
// - Peripheral read: 37, reply id, register, size, 1
// - Peripheral read answers 3, size bytes, 1 or 4,1
package cra_pkg;

  // ==========================================================================
  // Control tokens
  localparam logic [7:0] TOK_CFG_WR = 8'hC0;
  localparam logic [7:0] TOK_CFG_RD = 8'hC1;
  localparam logic [7:0] TOK_PER_WR = 8'h24;
  localparam logic [7:0] TOK_PER_RD = 8'h25;
  localparam logic [7:0] TOK_END = 8'h01;
  localparam logic [7:0] TOK_ACK = 8'h03;
  localparam logic [7:0] TOK_NAK = 8'h04;

  // ==========================================================================
  // Destination codes and field sizes
  localparam logic [15:0] DST_TILE = 16'hC20C;
  localparam logic [15:0] DST_NODE = 16'hC30C;
  localparam logic [7:0] DST_PERIPH = 8'h02;
  localparam logic [7:0] PS_LOW = 8'h0C;
  localparam int PS_SHIFT = 8;
  localparam logic [7:0] RID_BYTES = 8'h03;
  localparam logic [7:0] CFG_REG_BYTES = 8'h02;
  localparam logic [7:0] PER_REG_BYTES = 8'h01;
  localparam logic [7:0] CFG_DATA_BYTES = 8'h04;
  localparam logic [7:0] MAX_PER_BYTES = 8'h04;
  localparam logic [7:0] REQ_DATA_POS = 8'h06;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {CRA_SP_TILE, CRA_SP_NODE, CRA_SP_PERIPH}
    cra_space_t;
  typedef enum logic [3:0] {EP_HEAD, EP_RID, EP_REG, EP_SIZE, EP_DATA,
    EP_TAIL, EP_DROP, EP_EXEC, EP_SEND} cra_ep_state_t;
  typedef enum logic [2:0] {RQ_IDLE, RQ_SEND, RQ_HEAD, RQ_DATA, RQ_TAIL}
    cra_rq_state_t;

  // ==========================================================================
  // Helpers
  // Byte k of an nb-byte field sent most significant byte first
  function automatic logic [7:0] cra_pick(input logic [31:0] w,
      input logic [7:0] k, input logic [7:0] nb);
    logic [7:0] s;
    s = nb - k - 8'h01;
    cra_pick = (s < 8'h04) ? w[{s[1:0], 3'b000} +: 8] : 8'h00;
  endfunction : cra_pick

  function automatic logic [31:0] cra_ps_rid(input logic [15:0] r);
    cra_ps_rid = ({16'h0000, r} << PS_SHIFT) | {24'h00_0000, PS_LOW};
  endfunction : cra_ps_rid

endpackage : cra_pkg

// file: verif/config_reg_access_protocol_tb.sv
// Self-checking bench: requester and endpoint joined over the token link
`timescale 1ns/1ps
module config_reg_access_protocol_tb;
  typedef struct packed {
    logic wr;
    cra_pkg::cra_space_t sp;
    logic [15:0] addr;
    logic [7:0] size;
    logic [31:0] data;
    logic ok;
    logic req;
  } cra_row_t;
  localparam logic [15:0] TILE = 16'h0005;
  localparam logic [15:0] NODE = 16'h0009;
  localparam cra_pkg::cra_space_t ST = cra_pkg::CRA_SP_TILE;
  localparam cra_pkg::cra_space_t SN = cra_pkg::CRA_SP_NODE;
  localparam cra_pkg::cra_space_t SP = cra_pkg::CRA_SP_PERIPH;
  localparam cra_row_t ROWS [12] = '{
    '{1'b1, ST, 16'h0012, 8'h04, 32'h1234_5678, 1'b1, 1'b1},
    '{1'b0, ST, 16'h0034, 8'h04, 32'hA5C3_0F96, 1'b1, 1'b1},
    '{1'b1, SN, 16'h0101, 8'h04, 32'h0BAD_F00D, 1'b0, 1'b1},
    '{1'b0, SN, 16'h0202, 8'h04, 32'h6E5D_4C3B, 1'b1, 1'b1},
    '{1'b0, ST, 16'h0003, 8'h04, 32'h0000_0000, 1'b0, 1'b1},
    '{1'b0, SP, 16'h0011, 8'h04, 32'h89AB_CDEF, 1'b1, 1'b1},
    '{1'b0, SP, 16'h0022, 8'h01, 32'h0000_0077, 1'b1, 1'b1},
    '{1'b1, SP, 16'h0033, 8'h02, 32'h0000_5AA5, 1'b1, 1'b1},
    '{1'b0, SP, 16'h0044, 8'h03, 32'h0000_0000, 1'b0, 1'b1},
    '{1'b0, SP, 16'h0055, 8'h00, 32'h0000_0000, 1'b0, 1'b0},
    '{1'b0, SP, 16'h0066, 8'h05, 32'h0000_0000, 1'b0, 1'b0},
    '{1'b1, SP, 16'h0077, 8'h04, 32'h1357_9BDF, 1'b0, 1'b1}};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic wr = 1'b0;
  cra_pkg::cra_space_t sp = ST;
  logic [15:0] target = TILE;
  logic [15:0] addr = 16'h0000;
  logic [7:0] size = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [15:0] ps_reg = 16'h0000;
  logic cfg_ack = 1'b0;
  logic cfg_ok = 1'b0;
  logic [31:0] cfg_rdata = 32'h0000_0000;
  logic cfg_req, cfg_wr, busy, done, rq_ok;
  cra_pkg::cra_space_t cfg_space;
  logic [15:0] cfg_addr;
  logic [31:0] cfg_wdata, rdata, ps_rid;
  logic [7:0] cfg_size;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  int req_seen = 0;
  int seen;

  cra_if link();
  cra_endpoint #(.TILE_ID(TILE), .NODE_ID(NODE)) cra_endpoint_i (
    .CLK_I(clk), .RST_N_I(rst_n), .LINK(link), .CFG_REQ_O(cfg_req),
    .CFG_WR_O(cfg_wr), .CFG_SPACE_O(cfg_space), .CFG_ADDR_O(cfg_addr),
    .CFG_WDATA_O(cfg_wdata), .CFG_SIZE_O(cfg_size), .CFG_ACK_I(cfg_ack),
    .CFG_OK_I(cfg_ok), .CFG_RDATA_I(cfg_rdata));
  cra_requester cra_requester_i (
    .CLK_I(clk), .RST_N_I(rst_n), .LINK(link), .START_I(start), .WR_I(wr),
    .SPACE_I(sp), .TARGET_I(target), .PERIPH_I(8'h3A),
    .REPLY_I(24'h12_3456), .ADDR_I(addr), .SIZE_I(size), .WDATA_I(wdata),
    .PS_REG_I(ps_reg), .BUSY_O(busy), .DONE_O(done), .OK_O(rq_ok),
    .RDATA_O(rdata), .PS_RID_O(ps_rid));
  cra_link_sva cra_link_sva_i (
    .CLK_I(clk), .RST_N_I(rst_n), .req_valid(link.req_valid),
    .req_ready(link.req_ready), .req_ctrl(link.req_ctrl),
    .req_data(link.req_data), .req_dest(link.req_dest),
    .rsp_valid(link.rsp_valid), .rsp_ready(link.rsp_ready),
    .rsp_ctrl(link.rsp_ctrl), .rsp_data(link.rsp_data),
    .rsp_dest(link.rsp_dest));

  always #2 clk = ~clk;

  // Register side answers one cycle after each access request
  always @(posedge clk) begin
    cfg_ack <= cfg_req;
    if (cfg_req === 1'b1) begin
      req_seen <= req_seen + 1;
    end
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      failures++;
      conclude();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic run(input cra_row_t r);
    logic [31:0] m;
    int n;
    m = (r.sp == SP && r.size < 8'h04) ?
      (32'h0000_0001 << (8 * r.size)) - 32'h0000_0001 : 32'hFFFF_FFFF;
    seen = req_seen;
    @(posedge clk);
    start <= 1'b1;
    wr <= r.wr;
    sp <= r.sp;
    addr <= r.addr;
    size <= r.size;
    wdata <= r.data;
    cfg_rdata <= r.data;
    cfg_ok <= r.ok;
    target <= (r.sp == ST) ? TILE : NODE;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(32'(done), 32'h0000_0001);
    check(32'(rq_ok), 32'(r.ok));
    check(32'(req_seen - seen), 32'(r.req));
    if (r.req) begin
      check(32'(cfg_wr), 32'(r.wr));
      check(32'(cfg_space), 32'(r.sp));
      check(32'(cfg_addr), 32'(r.addr));
      check(32'(cfg_size), (r.sp == SP) ? 32'(r.size) : 32'h4);
    end
    if (r.req && r.wr) begin
      check(cfg_wdata & m, r.data & m);
    end
    if (r.ok && !r.wr) begin
      check(rdata & m, r.data & m);
    end
  endtask : run

  task automatic conclude;
    if (failures == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (15) @(posedge clk);
    #1;
    check(32'({busy, done, link.req_valid, link.rsp_valid}), 32'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    ps_reg <= 16'hBEEF;
    foreach (ROWS[i]) begin
      run(ROWS[i]);
    end
    check(ps_rid, 32'h00BE_EF0C);
    // Wrong tile id: message dropped, nothing answered
    seen = req_seen;
    @(posedge clk);
    start <= 1'b1;
    sp <= ST;
    wr <= 1'b0;
    target <= 16'h0077;
    @(posedge clk);
    start <= 1'b0;
    repeat (60) @(posedge clk);
    #1;
    check(32'({busy, link.rsp_valid}), 32'h2);
    check(32'(req_seen - seen), 32'h0);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check(32'(busy), 32'h0);
    run(ROWS[1]);
    conclude();
  end
endmodule : config_reg_access_protocol_tb

// file: verif/cra_link_sva.sv
// Assertions on the token link between requester and endpoint
`timescale 1ns/1ps
module cra_link_sva (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_ctrl,
  input wire logic [7:0] req_data,
  input wire logic [31:0] req_dest,
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire logic rsp_ctrl,
  input wire logic [7:0] rsp_data,
  input wire logic [23:0] rsp_dest
);
  // ==========================================================================
  // Message tracking
  logic req_start_reg;
  logic rsp_start_reg;
  logic rsp_nak_reg;
  logic [7:0] hdr_reg;
  logic [7:0] size_reg;
  logic [7:0] idx_reg;
  logic [7:0] cnt_reg;
  logic [23:0] rid_reg;
  wire logic req_go = req_valid && req_ready;
  wire logic rsp_go = rsp_valid && rsp_ready;
  wire logic rsp_end = rsp_go && rsp_ctrl && rsp_data == cra_pkg::TOK_END;
  wire logic [7:0] exp_cnt = rsp_nak_reg ? 8'h00 :
    (hdr_reg == cra_pkg::TOK_CFG_RD) ? 8'h04 :
    (hdr_reg == cra_pkg::TOK_PER_RD) ? size_reg : 8'h00;

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      req_start_reg <= 1'b1;
      hdr_reg <= 8'h00;
      idx_reg <= 8'h00;
      size_reg <= 8'h00;
      rid_reg <= 24'h00_0000;
    end else if (req_go && req_ctrl) begin
      req_start_reg <= req_data == cra_pkg::TOK_END;
      if (req_start_reg) begin
        hdr_reg <= req_data;
      end
      idx_reg <= 8'h00;
    end else if (req_go) begin
      idx_reg <= idx_reg + 8'h01;
      if (idx_reg < 8'h03) begin
        rid_reg <= {rid_reg[15:0], req_data};
      end
      if (idx_reg == 8'h04) begin
        size_reg <= req_data;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      rsp_start_reg <= 1'b1;
      rsp_nak_reg <= 1'b0;
      cnt_reg <= 8'h00;
    end else if (rsp_go && rsp_ctrl) begin
      rsp_start_reg <= rsp_data == cra_pkg::TOK_END;
      cnt_reg <= 8'h00;
      if (rsp_start_reg) begin
        rsp_nak_reg <= rsp_data == cra_pkg::TOK_NAK;
      end
    end else if (rsp_go) begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  a_req_hold: assert property (req_valid && !req_ready |=> req_valid &&
    $stable(req_data) && $stable(req_ctrl) && $stable(req_dest))
    else $error("request token changed before it was taken");
  a_rsp_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid &&
    $stable(rsp_data) && $stable(rsp_ctrl))
    else $error("answer token changed before it was taken");
  a_req_head: assert property (req_valid && req_start_reg |-> req_ctrl &&
    req_data inside {8'hC0, 8'hC1, 8'h24, 8'h25})
    else $error("message does not open with a header token");
  a_req_dest: assert property (req_valid |->
    req_dest[15:0] inside {16'hC20C, 16'hC30C} || req_dest[7:0] == 8'h02)
    else $error("request aimed at an unknown endpoint code");
  a_rsp_first: assert property (rsp_valid && rsp_start_reg |-> rsp_ctrl &&
    rsp_data inside {8'h03, 8'h04})
    else $error("answer does not open with success or failure");
  a_nak_end: assert property (rsp_go && rsp_ctrl && rsp_data == 8'h04
    |=> rsp_valid && rsp_ctrl && rsp_data == 8'h01)
    else $error("failure not followed by closing token");
  a_rsp_len: assert property (rsp_end |-> cnt_reg == exp_cnt)
    else $error("answer carries a wrong number of data bytes");
  a_rsp_dest: assert property (rsp_valid |-> rsp_dest == rid_reg)
    else $error("answer sent to a wrong channel-end");
  a_busy_refuse: assert property (rsp_valid |-> !req_ready)
    else $error("request accepted while answering");

  c_nak: cover property (rsp_go && rsp_ctrl && rsp_data == 8'h04);
  c_cfg_rd: cover property (rsp_end && hdr_reg == 8'hC1 && !rsp_nak_reg);
  c_per_rd: cover property (rsp_end && hdr_reg == 8'h25 && !rsp_nak_reg);
endmodule : cra_link_sva
